// ### hdl/thr_cmp_pkg.sv
// Package: constants, types and carriers for the analog threshold comparator
package thr_cmp_pkg;

	// ----------------------------------------------------------------
	// Widths and timing
	// ----------------------------------------------------------------
	localparam int VAL_W = 32;
	localparam int PU_W = 16;
	localparam int PU_FRAC = 8;
	localparam int HYST_W = 10;
	localparam int DLY_W = 16;
	localparam int CLOCK_HZ = 10_000_000;
	localparam int MS_TIME_US = 1000;
	localparam int MS_CYCLES = CLOCK_HZ / 1_000_000 * MS_TIME_US;
	localparam int HYST_SCALE = 1000;

	// ----------------------------------------------------------------
	// Fixed bases, in the engine's value units
	// ----------------------------------------------------------------
	localparam logic [VAL_W-1:0] BASE_FREQ = 32'h0000_0001;
	localparam logic [VAL_W-1:0] BASE_ANGLE = 32'h0000_0168;
	localparam logic [VAL_W-1:0] BASE_PF = 32'h0000_0064;
	localparam logic [VAL_W-1:0] BASE_RTD = 32'h0000_0064;
	localparam logic [VAL_W-1:0] BASE_ARC = 32'h0000_07D0;

	// Interval unit multipliers, in milliseconds
	localparam logic [VAL_W-1:0] UNIT_MS_MULT = 32'h0000_0001;
	localparam logic [VAL_W-1:0] UNIT_S_MULT = 32'h0000_03E8;
	localparam logic [VAL_W-1:0] UNIT_MIN_MULT = 32'h0000_EA60;

	// Reset values
	localparam logic [VAL_W-1:0] VAL_RST = 32'h0000_0000;
	localparam logic [DLY_W-1:0] TMR_RST = 16'h0000;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		QTY_CURRENT = 4'h0,
		QTY_VOLTAGE = 4'h1,
		QTY_POWER = 4'h2,
		QTY_DCMA = 4'h3,
		QTY_FREQ = 4'h4,
		QTY_ANGLE = 4'h5,
		QTY_PF = 4'h6,
		QTY_RTD = 4'h7,
		QTY_ARC = 4'h8
	} qty_e;

	typedef enum logic [1:0] {
		UNIT_MS = 2'h0,
		UNIT_S = 2'h1,
		UNIT_MIN = 2'h2
	} unit_e;

	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_PICKING = 2'h1,
		ST_OPERATED = 2'h2,
		ST_RESETTING = 2'h3
	} elem_state_e;

	// One analog input as delivered by the measurement engine
	typedef struct packed {
		logic sel_on;
		qty_e qty;
		logic signed [VAL_W-1:0] value;
		logic [VAL_W-1:0] base;
	} analog_s;

	// Settings of the element
	typedef struct packed {
		logic sign_handling_mode;
		logic level_or_delta_mode;
		logic over_under_direction;
		logic signed [PU_W-1:0] threshold_value;
		logic [HYST_W-1:0] hysteresis_percent;
		unit_e interval_time_unit;
		logic [DLY_W-1:0] delta_interval;
		logic [DLY_W-1:0] assert_delay;
		logic [DLY_W-1:0] deassert_delay;
	} settings_s;

endpackage

// ### hdl/analog_threshold_comparator.sv
// Analog threshold comparator with hysteresis, delta mode and pickup/reset delays
//
// Contract
// RQ1 - Non-inverted input is the selected quantity, zero when its selection is off.
// RQ2 - Operating signal is non-inverted minus inverted; inverted is zero when off.
// RQ3 - With no input selected the output is never asserted.
// RQ4 - Inputs of different quantity types disable the element; output stays low.
// RQ5 - Signed mode uses the difference with its sign.
// RQ6 - Absolute mode uses the magnitude of the difference.
// RQ7 - Level mode compares the operating signal itself.
// RQ8 - Delta mode compares the change of the signal over the interval.
// RQ9 - Interval and its unit are used only in delta mode.
// RQ10 - Over direction picks up when the quantity rises above the threshold.
// RQ11 - Under direction picks up when the quantity drops below the threshold.
// RQ12 - Threshold and quantity are signed, so negative thresholds work.
// RQ13 - Dropout point comes from hysteresis, a percentage of the threshold.
// RQ14 - Threshold is per unit; fixed bases for frequency, angle, PF, RTD.
// RQ15 - Current, voltage and power bases are the larger of the two inputs.
// RQ16 - Transducer base is the larger of the two range maxima.
// RQ17 - Arcing-current base is 2000 kA-squared cycles.
// RQ18 - Output asserts after pickup delay and deasserts after reset delay.
// RQ19 - Dropout only beyond threshold minus (over) or plus (under) hysteresis width.
// RQ20 - Recompute on every processing tick; delays counted from configured times.
`timescale 1ns/100ps

module analog_threshold_comparator #(
	parameter int MS_CYCLES = thr_cmp_pkg::MS_CYCLES
) (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic tick,
	input wire thr_cmp_pkg::analog_s positive_input_select,
	input wire thr_cmp_pkg::analog_s negative_input_select,
	input wire thr_cmp_pkg::settings_s cfg,
	output logic operate_q,
	output logic pickup_q,
	output logic element_valid_q,
	output logic signed [thr_cmp_pkg::VAL_W:0] op_signal_q
);

	localparam int VW = thr_cmp_pkg::VAL_W;
	localparam int TW = 2 * VW + 2;
	localparam logic [31:0] MS_LAST = 32'(MS_CYCLES - 1);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		thr_cmp_pkg::elem_state_e fsm;
		logic operate;
		logic pickup;
		logic valid;
		logic signed [VW:0] op_sig;
		logic signed [VW:0] ref_sig;
		logic signed [VW+1:0] delta;
		logic [31:0] ms_cnt;
		logic [31:0] iv_cnt;
		logic [thr_cmp_pkg::DLY_W-1:0] tmr;
	} state_s;

	state_s st_q;
	state_s st_d;

	// ----------------------------------------------------------------
	// Operating signal
	// ----------------------------------------------------------------
	logic signed [VW:0] pos_val;
	logic signed [VW:0] neg_val;
	logic signed [VW:0] diff;
	logic signed [VW:0] op_now;
	logic both_off;
	logic type_clash;
	logic valid_c;
	thr_cmp_pkg::qty_e qty;
	logic [VW-1:0] pos_base;
	logic [VW-1:0] neg_base;
	logic [VW-1:0] base;
	logic signed [TW-1:0] thr;
	logic signed [TW-1:0] thr_abs;
	logic signed [TW-1:0] hw;
	logic signed [TW-1:0] cmp;
	logic pick_c;
	logic hold_c;
	logic pickup_c;
	logic ms_en;
	logic [31:0] iv_len;

	always_comb begin
		pos_val = positive_input_select.sel_on ? (VW+1)'(positive_input_select.value) : '0; // [RQ1]
		neg_val = negative_input_select.sel_on ? (VW+1)'(negative_input_select.value) : '0; // [RQ2]
		diff = pos_val - neg_val; // [RQ2]
		if (cfg.sign_handling_mode && diff < 0) begin
			op_now = -diff; // [RQ6]
		end else begin
			op_now = diff; // [RQ5]
		end
		both_off = !positive_input_select.sel_on && !negative_input_select.sel_on;
		type_clash = positive_input_select.sel_on && negative_input_select.sel_on
			&& (positive_input_select.qty != negative_input_select.qty);
		valid_c = !both_off && !type_clash; // [RQ3] [RQ4]
		qty = positive_input_select.sel_on ? positive_input_select.qty
			: negative_input_select.qty;
	end

	// ----------------------------------------------------------------
	// Per-unit threshold and hysteresis
	// ----------------------------------------------------------------
	always_comb begin
		pos_base = positive_input_select.sel_on ? positive_input_select.base : '0;
		neg_base = negative_input_select.sel_on ? negative_input_select.base : '0;
		case (qty)
			thr_cmp_pkg::QTY_FREQ: base = thr_cmp_pkg::BASE_FREQ; // [RQ14]
			thr_cmp_pkg::QTY_ANGLE: base = thr_cmp_pkg::BASE_ANGLE; // [RQ14]
			thr_cmp_pkg::QTY_PF: base = thr_cmp_pkg::BASE_PF; // [RQ14]
			thr_cmp_pkg::QTY_RTD: base = thr_cmp_pkg::BASE_RTD; // [RQ14]
			thr_cmp_pkg::QTY_ARC: base = thr_cmp_pkg::BASE_ARC; // [RQ17]
			// Current, voltage, power and transducers take the larger input base
			default: base = (pos_base > neg_base) ? pos_base : neg_base; // [RQ15] [RQ16]
		endcase
		// Signed product keeps negative thresholds negative
		thr = (TW'(cfg.threshold_value) * $signed({2'b00, base})) >>> thr_cmp_pkg::PU_FRAC; // [RQ12]
		thr_abs = (thr < 0) ? -thr : thr;
		// Width is taken from the threshold magnitude so it never flips sign
		hw = (thr_abs * $signed({{(TW-thr_cmp_pkg::HYST_W){1'b0}}, cfg.hysteresis_percent}))
			/ TW'(thr_cmp_pkg::HYST_SCALE); // [RQ13]
		cmp = cfg.level_or_delta_mode ? TW'(st_q.delta) : TW'(st_q.op_sig); // [RQ7] [RQ8]
		if (!cfg.over_under_direction) begin
			pick_c = cmp > thr; // [RQ10]
			hold_c = cmp >= thr - hw; // [RQ19]
		end else begin
			pick_c = cmp < thr; // [RQ11]
			hold_c = cmp <= thr + hw; // [RQ19]
		end
		pickup_c = st_q.pickup ? hold_c : pick_c;
	end

	// ----------------------------------------------------------------
	// Millisecond enable and delta interval
	// ----------------------------------------------------------------
	always_comb begin
		ms_en = st_q.ms_cnt == MS_LAST;
		case (cfg.interval_time_unit)
			thr_cmp_pkg::UNIT_S: iv_len = 32'(cfg.delta_interval) * thr_cmp_pkg::UNIT_S_MULT;
			thr_cmp_pkg::UNIT_MIN: iv_len = 32'(cfg.delta_interval) * thr_cmp_pkg::UNIT_MIN_MULT;
			default: iv_len = 32'(cfg.delta_interval) * thr_cmp_pkg::UNIT_MS_MULT;
		endcase
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		st_d = st_q;
		st_d.ms_cnt = ms_en ? 32'h0000_0000 : st_q.ms_cnt + 32'h0000_0001; // [RQ20]
		st_d.valid = valid_c;
		if (tick) begin
			st_d.op_sig = op_now; // [RQ20]
		end
		// Interval timing is frozen in level mode so no stale change is kept
		if (!cfg.level_or_delta_mode) begin
			st_d.iv_cnt = 32'h0000_0000; // [RQ9]
			st_d.delta = '0;
			st_d.ref_sig = st_q.op_sig;
		end else if (ms_en) begin
			if (st_q.iv_cnt + 32'h0000_0001 >= iv_len) begin
				st_d.iv_cnt = 32'h0000_0000;
				st_d.delta = (VW+2)'(st_q.op_sig) - (VW+2)'(st_q.ref_sig); // [RQ8]
				st_d.ref_sig = st_q.op_sig;
			end else begin
				st_d.iv_cnt = st_q.iv_cnt + 32'h0000_0001;
			end
		end
		// Judged on the signal latched at the previous tick: one tick of latency
		if (tick) begin
			st_d.pickup = pickup_c && valid_c; // [RQ20]
		end
		case (st_q.fsm)
			thr_cmp_pkg::ST_IDLE: begin
				st_d.tmr = thr_cmp_pkg::TMR_RST;
				if (st_q.pickup) begin
					st_d.fsm = (cfg.assert_delay == '0) ? thr_cmp_pkg::ST_OPERATED
						: thr_cmp_pkg::ST_PICKING; // [RQ18]
				end
			end
			thr_cmp_pkg::ST_PICKING: begin
				if (!st_q.pickup) begin
					st_d.fsm = thr_cmp_pkg::ST_IDLE;
				end else if (ms_en) begin
					st_d.tmr = st_q.tmr + 16'h0001;
					if (st_q.tmr + 16'h0001 >= cfg.assert_delay) begin
						st_d.fsm = thr_cmp_pkg::ST_OPERATED; // [RQ18]
					end
				end
			end
			thr_cmp_pkg::ST_OPERATED: begin
				st_d.tmr = thr_cmp_pkg::TMR_RST;
				if (!st_q.pickup) begin
					st_d.fsm = (cfg.deassert_delay == '0) ? thr_cmp_pkg::ST_IDLE
						: thr_cmp_pkg::ST_RESETTING; // [RQ18]
				end
			end
			thr_cmp_pkg::ST_RESETTING: begin
				if (st_q.pickup) begin
					st_d.fsm = thr_cmp_pkg::ST_OPERATED;
					st_d.tmr = thr_cmp_pkg::TMR_RST;
				end else if (ms_en) begin
					st_d.tmr = st_q.tmr + 16'h0001;
					if (st_q.tmr + 16'h0001 >= cfg.deassert_delay) begin
						st_d.fsm = thr_cmp_pkg::ST_IDLE; // [RQ18]
					end
				end
			end
			default: st_d.fsm = thr_cmp_pkg::ST_IDLE;
		endcase
		// A disabled element drops at once, bypassing the reset delay
		if (!valid_c) begin
			st_d.fsm = thr_cmp_pkg::ST_IDLE; // [RQ3] [RQ4]
			st_d.pickup = 1'b0;
			st_d.tmr = thr_cmp_pkg::TMR_RST;
		end
		st_d.operate = (st_d.fsm == thr_cmp_pkg::ST_OPERATED)
			|| (st_d.fsm == thr_cmp_pkg::ST_RESETTING);
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			st_q.fsm <= thr_cmp_pkg::ST_IDLE;
			st_q.operate <= 1'b0;
			st_q.pickup <= 1'b0;
			st_q.valid <= 1'b0;
			st_q.op_sig <= '0;
			st_q.ref_sig <= '0;
			st_q.delta <= '0;
			st_q.ms_cnt <= thr_cmp_pkg::VAL_RST;
			st_q.iv_cnt <= thr_cmp_pkg::VAL_RST;
			st_q.tmr <= thr_cmp_pkg::TMR_RST;
		end else begin
			st_q <= st_d;
		end
	end

	assign operate_q = st_q.operate;
	assign pickup_q = st_q.pickup;
	assign element_valid_q = st_q.valid;
	assign op_signal_q = st_q.op_sig;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);

	AST_NO_INPUT_NO_OUTPUT: assert property (both_off |=> !operate_q && !pickup_q) // [RQ3]
		else $error("output asserted with no input selected");
	AST_TYPE_CLASH_OFF: assert property (type_clash |=> !operate_q && !pickup_q) // [RQ4]
		else $error("output asserted with mixed input types");
	AST_SIGNED_DIFF: assert property (tick && !cfg.sign_handling_mode |=> // [RQ5]
		op_signal_q == $past(pos_val) - $past(neg_val))
		else $error("signed operating signal is not the input difference");
	AST_ABS_NONNEG: assert property (tick && cfg.sign_handling_mode |=> // [RQ6]
		op_signal_q >= 0 && (op_signal_q == $past(diff) || op_signal_q == -$past(diff)))
		else $error("absolute operating signal wrong");
	AST_OFF_IS_ZERO: assert property (tick && !negative_input_select.sel_on // [RQ2]
		&& !cfg.sign_handling_mode |=> op_signal_q == $past(pos_val))
		else $error("inverted input not taken as zero when off");
	AST_OVER_PICK: assert property (tick && valid_c && !cfg.over_under_direction // [RQ10]
		&& cmp > thr |=> pickup_q)
		else $error("over pickup missed");
	AST_UNDER_PICK: assert property (tick && valid_c && cfg.over_under_direction // [RQ11]
		&& cmp < thr |=> pickup_q)
		else $error("under pickup missed");
	AST_HYST_HOLD: assert property (tick && valid_c && pickup_q && !cfg.over_under_direction // [RQ19]
		&& cmp >= thr - hw |=> pickup_q)
		else $error("dropped out inside hysteresis band");
	AST_DELAY_ABORT: assert property (st_q.fsm == thr_cmp_pkg::ST_PICKING && !pickup_q // [RQ18]
		|=> !operate_q)
		else $error("output asserted before pickup delay elapsed");
	AST_LEVEL_NO_DELTA: assert property (!cfg.level_or_delta_mode |=> st_q.iv_cnt == 0) // [RQ9]
		else $error("interval timer running in level mode");
	AST_MS_PERIOD: assert property (ms_en |=> !ms_en [*2]) // [RQ20]
		else $error("millisecond enable too frequent");

	// ----------------------------------------------------------------
	// Comparator, validity, tick-timing and scaling checks
	// ----------------------------------------------------------------
	AST_OVER_DROP: assert property (tick && valid_c && !cfg.over_under_direction // [RQ19]
		&& cmp < thr - hw |=> !pickup_q)
		else $error("over pickup held below hysteresis band");
	AST_UNDER_HOLD: assert property (tick && valid_c && pickup_q // [RQ19]
		&& cfg.over_under_direction && cmp <= thr + hw |=> pickup_q)
		else $error("under pickup dropped inside hysteresis band");
	AST_UNDER_DROP: assert property (tick && valid_c && cfg.over_under_direction // [RQ19]
		&& cmp > thr + hw |=> !pickup_q)
		else $error("under pickup held above hysteresis band");
	AST_VALID_SET: assert property (valid_c |=> element_valid_q) // [RQ3] [RQ4]
		else $error("valid flag missing for a valid input pair");
	AST_INVALID_IDLE: assert property (!valid_c |=> !element_valid_q // [RQ3] [RQ4]
		&& st_q.fsm == thr_cmp_pkg::ST_IDLE)
		else $error("invalid inputs left the element active");
	AST_PICKUP_ON_TICK: assert property (!tick && valid_c |=> $stable(pickup_q)) // [RQ20]
		else $error("pickup changed between ticks");
	AST_OP_ON_TICK: assert property (!tick |=> $stable(op_signal_q)) // [RQ20]
		else $error("operating signal changed between ticks");
	AST_THR_SIGN: assert property (cfg.threshold_value[thr_cmp_pkg::PU_W-1] && base != '0 // [RQ12]
		|-> thr < 0)
		else $error("negative threshold lost its sign");
	AST_ARC_BASE: assert property (qty == thr_cmp_pkg::QTY_ARC // [RQ17]
		|-> base == thr_cmp_pkg::BASE_ARC)
		else $error("arcing base is not the fixed value");
	AST_ANGLE_BASE: assert property (qty == thr_cmp_pkg::QTY_ANGLE // [RQ14]
		|-> base == thr_cmp_pkg::BASE_ANGLE)
		else $error("angle base is not the fixed value");
	AST_LARGER_BASE: assert property ((qty == thr_cmp_pkg::QTY_CURRENT // [RQ15] [RQ16]
		|| qty == thr_cmp_pkg::QTY_DCMA) |-> base >= pos_base && base >= neg_base)
		else $error("scaling base is not the larger input base");
	AST_HW_ZERO: assert property (cfg.hysteresis_percent == '0 |-> hw == '0) // [RQ13]
		else $error("hysteresis width without a hysteresis setting");

	// ----------------------------------------------------------------
	// Delay and interval checks
	// ----------------------------------------------------------------
	AST_ZERO_PICK_DELAY: assert property (st_q.fsm == thr_cmp_pkg::ST_IDLE // [RQ18]
		&& pickup_q && valid_c && cfg.assert_delay == '0 |=> operate_q)
		else $error("output late with zero pickup delay");
	AST_ZERO_RESET_DELAY: assert property (st_q.fsm == thr_cmp_pkg::ST_OPERATED // [RQ18]
		&& !pickup_q && cfg.deassert_delay == '0 |=> !operate_q)
		else $error("output held with zero reset delay");
	AST_RESET_DELAY_HOLD: assert property (st_q.fsm == thr_cmp_pkg::ST_RESETTING // [RQ18]
		&& pickup_q && valid_c |=> operate_q)
		else $error("pickup return during reset delay dropped the output");
	AST_OPERATE_AFTER_PICKUP: assert property ($rose(operate_q) |-> $past(pickup_q)) // [RQ18]
		else $error("output rose without a pickup");
	AST_PICK_WAITS_MS: assert property (st_q.fsm == thr_cmp_pkg::ST_PICKING && !ms_en // [RQ18]
		|=> !operate_q)
		else $error("pickup delay ended off a millisecond step");
	AST_DELTA_FROZEN: assert property (!cfg.level_or_delta_mode |=> st_q.delta == '0) // [RQ9]
		else $error("stale change kept in level mode");
	AST_DELTA_HELD: assert property (cfg.level_or_delta_mode && !ms_en // [RQ8]
		|=> $stable(st_q.delta))
		else $error("change value moved inside an interval");

	// ----------------------------------------------------------------
	// Cover points
	// ----------------------------------------------------------------
	COV_OPERATE: cover property ($rose(operate_q));
	COV_HYST_HOLD: cover property (tick && pickup_q && hold_c && !pick_c);
	COV_DELTA_OPERATE: cover property (cfg.level_or_delta_mode && $rose(operate_q));
	COV_UNDER_OPERATE: cover property (cfg.over_under_direction && $rose(operate_q));
	COV_RESET_DELAY: cover property (st_q.fsm == thr_cmp_pkg::ST_RESETTING ##1 !operate_q);

endmodule

// ### tb/meas_engine_model.sv
// Behavioural measurement engine: processing tick and per-pass analog values
`timescale 1ns/100ps

module meas_engine_model #(
	parameter int TICK_DIV = 3
) (
	input wire logic clock,
	input wire logic sys_rst,
	input wire thr_cmp_pkg::analog_s want_pos,
	input wire thr_cmp_pkg::analog_s want_neg,
	output logic tick,
	output thr_cmp_pkg::analog_s pos_out,
	output thr_cmp_pkg::analog_s neg_out
);
	// ----------------------------------------------------------------
	// Tick divider and value publishing
	// ----------------------------------------------------------------
	// Values change only on a pass boundary, so a tick never sees a half-updated pair
	int cnt;

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			cnt <= 0;
			tick <= 1'h0;
			pos_out <= '0;
			neg_out <= '0;
		end else begin
			cnt <= (cnt == TICK_DIV - 1) ? 0 : cnt + 1;
			tick <= (cnt == TICK_DIV - 1);
			if (cnt == TICK_DIV - 1) begin
				pos_out <= want_pos;
				neg_out <= want_neg;
			end
		end
	end
endmodule

// ### tb/tb.sv
// Self-checking bench for the analog threshold comparator
`timescale 1ns/100ps

module tb;
	// Short millisecond so delays and intervals stay a few clocks long
	localparam int MSC = 4;
	logic clock;
	logic sys_rst;
	logic tick;
	thr_cmp_pkg::analog_s want_pos;
	thr_cmp_pkg::analog_s want_neg;
	thr_cmp_pkg::analog_s pos_in;
	thr_cmp_pkg::analog_s neg_in;
	thr_cmp_pkg::analog_s off;
	thr_cmp_pkg::settings_s cfg;
	logic operate_q;
	logic pickup_q;
	logic element_valid_q;
	logic signed [thr_cmp_pkg::VAL_W:0] op_signal_q;
	int error_cnt;
	int compares;
	int n;
	int m;

	meas_engine_model u_meas_engine_model (
		.clock(clock), .sys_rst(sys_rst), .want_pos(want_pos), .want_neg(want_neg),
		.tick(tick), .pos_out(pos_in), .neg_out(neg_in)
	);

	analog_threshold_comparator #(.MS_CYCLES(MSC)) u_analog_threshold_comparator (
		.clock(clock), .sys_rst(sys_rst), .tick(tick),
		.positive_input_select(pos_in), .negative_input_select(neg_in), .cfg(cfg),
		.operate_q(operate_q), .pickup_q(pickup_q), .element_valid_q(element_valid_q),
		.op_signal_q(op_signal_q)
	);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic thr_cmp_pkg::analog_s a(input logic s, input logic [3:0] q,
			input logic [31:0] v, input logic [31:0] b);
		a = {s, thr_cmp_pkg::qty_e'(q), v, b};
	endfunction

	function automatic thr_cmp_pkg::analog_s cu(input logic [31:0] v);
		cu = a(1'h1, 4'h0, v, 32'h64);
	endfunction

	task automatic chk_bit(input logic got, input logic exp);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_val(input logic [32:0] got, input logic [32:0] exp);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Counts clocks until operate (op=1) or pickup reaches the level
	task automatic wt(input logic op, input logic lv, output int cnt);
		cnt = 0;
		while ((op ? operate_q : pickup_q) !== lv && cnt < 300) begin
			@(posedge clock);
			#1;
			cnt++;
		end
	endtask

	// One settled case: mode bits are {absolute, delta, under}
	task automatic row(input thr_cmp_pkg::analog_s p, input thr_cmp_pkg::analog_s q,
			input logic [2:0] md, input logic [15:0] t, input logic ev, input logic ep);
		logic signed [32:0] d;
		d = (p.sel_on ? 33'(p.value) : 33'sh0) - (q.sel_on ? 33'(q.value) : 33'sh0);
		if (md[2] && d < 0) d = -d;
		want_pos = p;
		want_neg = q;
		cfg.sign_handling_mode = md[2];
		cfg.level_or_delta_mode = md[1];
		cfg.over_under_direction = md[0];
		cfg.threshold_value = t;
		repeat (40) @(posedge clock);
		#1;
		chk_bit(element_valid_q, ev);
		chk_bit(pickup_q, ep);
		chk_bit(operate_q, ep);
		if (ev) chk_val(op_signal_q, d);
	endtask

	task automatic end_sim;
		$display("compares %0d error_cnt %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Clock, watchdog and test sequence
	// ----------------------------------------------------------------
	initial begin
		clock = 1'h0;
		forever #50 clock = ~clock;
	end

	initial begin
		#2_000_000;
		error_cnt++;
		end_sim();
	end

	initial begin
		error_cnt = 0;
		compares = 0;
		sys_rst = 1'h1;
		off = '0;
		want_pos = '0;
		want_neg = '0;
		cfg = '0;
		cfg.hysteresis_percent = 10'h064;
		cfg.interval_time_unit = thr_cmp_pkg::UNIT_MIN;
		cfg.delta_interval = 16'h0002;
		repeat (12) @(posedge clock);
		#1;
		sys_rst = 1'h0;
		row(off, off, 3'h0, 16'h0100, 1'h0, 1'h0);
		row(cu(32'h12C), off, 3'h0, 16'h0100, 1'h1, 1'h1);
		row(cu(32'h5F), off, 3'h0, 16'h0100, 1'h1, 1'h1);
		row(cu(32'h55), off, 3'h0, 16'h0100, 1'h1, 1'h0);
		row(cu(32'h12C), cu(32'hFA), 3'h0, 16'h0100, 1'h1, 1'h0);
		row(off, cu(32'h12C), 3'h0, 16'h0100, 1'h1, 1'h0);
		row(off, cu(32'h12C), 3'h4, 16'h0100, 1'h1, 1'h1);
		row(cu(32'h12C), a(1'h1, 4'h1, 32'h0, 32'h64), 3'h0, 16'h0100, 1'h0, 1'h0);
		row(cu(32'h32), off, 3'h1, 16'h0100, 1'h1, 1'h1);
		row(cu(32'h69), off, 3'h1, 16'h0100, 1'h1, 1'h1);
		row(cu(32'h73), off, 3'h1, 16'h0100, 1'h1, 1'h0);
		row(a(1'h1, 4'h2, 32'hFFFFFF38, 32'h64), off, 3'h1, 16'hFF00, 1'h1, 1'h1);
		row(a(1'h1, 4'h3, 32'h1F4, 32'h64), a(1'h1, 4'h3, 32'h0, 32'h190), 3'h0, 16'h0100,
			1'h1, 1'h1);
		row(cu(32'h12C), a(1'h1, 4'h0, 32'h0, 32'h190), 3'h0, 16'h0100, 1'h1, 1'h0);
		row(a(1'h1, 4'h4, 32'h2, 32'h3E8), off, 3'h0, 16'h0100, 1'h1, 1'h1);
		row(a(1'h1, 4'h5, 32'h64, 32'h3E8), off, 3'h0, 16'h0040, 1'h1, 1'h1);
		row(a(1'h1, 4'h6, 32'h96, 32'h3E8), off, 3'h0, 16'h0100, 1'h1, 1'h1);
		row(a(1'h1, 4'h7, 32'h96, 32'h3E8), off, 3'h0, 16'h0100, 1'h1, 1'h1);
		row(a(1'h1, 4'h8, 32'h5DC, 32'h64), off, 3'h0, 16'h0100, 1'h1, 1'h0);
		row(a(1'h1, 4'h8, 32'h9C4, 32'h64), off, 3'h0, 16'h0100, 1'h1, 1'h1);
		cfg.interval_time_unit = thr_cmp_pkg::UNIT_MS;
		row(cu(32'h12C), off, 3'h2, 16'h0100, 1'h1, 1'h0);
		// A step of 1000 shows up as one interval of change, then falls away
		want_pos = cu(32'h514);
		wt(1'h0, 1'h1, n);
		chk_bit(n < 40, 1'h1);
		wt(1'h0, 1'h0, n);
		chk_bit(n < 60, 1'h1);
		cfg.level_or_delta_mode = 1'h0;
		cfg.assert_delay = 16'h0003;
		cfg.deassert_delay = 16'h0002;
		want_pos = cu(32'h0);
		repeat (40) @(posedge clock);
		#1;
		want_pos = cu(32'h12C);
		wt(1'h0, 1'h1, n);
		wt(1'h1, 1'h1, m);
		chk_bit(m >= 2 * MSC - 1 && m <= 3 * MSC + 2, 1'h1);
		want_pos = cu(32'h0);
		wt(1'h0, 1'h0, n);
		wt(1'h1, 1'h0, m);
		chk_bit(m >= MSC - 1 && m <= 2 * MSC + 2, 1'h1);
		// Pickup that drops before the delay runs out never operates
		want_pos = cu(32'h12C);
		wt(1'h0, 1'h1, n);
		want_pos = cu(32'h0);
		repeat (6 * MSC) @(posedge clock);
		#1;
		chk_bit(operate_q, 1'h0);
		end_sim();
	end
endmodule
